// file: shared/pfd_pkg.sv
// constants for the pixel flag and dac width control block
// Overview of operation
// - split mode: flag rise in blanking adds shift
// - nibble mode samples flag on video clock fall
// - sampled flag picks upper or lower nibble
// - both mode bits clear: flag ignored
// - write data captured on strobe rising edge
// - width high: all eight data lines used
// - width low: bits 5..0 shifted up two
// - 6-bit reads zero two msbs, storage full
// - drive programmable video clock output
// - pass-through bus feeds pixels unmultiplexed
// - shift clock divides dot clock, off in blanking
package pfd_pkg;
   localparam int          PFD_MODE_SPLIT_BIT  = 2;
   localparam int          PFD_MODE_NIBBLE_BIT = 3;
   localparam logic [7:0]  PFD_CTRL_RESET      = 8'h00;
   localparam logic [7:0]  PFD_BYTE_ZERO       = 8'h00;
   localparam int          PFD_SHIFT_DIV       = 4;
   localparam int          PFD_VIDEO_DIV       = 8;
   localparam int          PFD_SYNC_STAGES     = 3;
   typedef enum logic [1:0] {PFD_OFF, PFD_SPLIT, PFD_NIBBLE, PFD_ILLEGAL} pfd_mode_t;
endpackage

// file: hdl/pfd_core.sv
// pixel flag, shift/video clock and dac width control
`timescale 1ns/10ps
module pfd_core
   import pfd_pkg::*;
#(
   parameter int PIX_BYTES = 4,
   parameter int SHIFT_DIV = PFD_SHIFT_DIV,
   parameter int VIDEO_DIV = PFD_VIDEO_DIV
) (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic [7:0]             ctrl_reg,
   input  wire logic                   blank_in,
   input  wire logic                   transfer_or_nibble_flag,
   input  wire logic                   pass_through_en,
   input  wire logic [8*PIX_BYTES-1:0] pixel_bus,
   input  wire logic [7:0]             pass_bus,
   input  wire logic                   wr_strobe_n,
   input  wire logic [7:0]             data_in,
   input  wire logic                   width_sel,
   input  wire logic [7:0]             hold_entry,
   output logic                        shift_clk_out,
   output logic                        video_clock_out,
   output logic [8*PIX_BYTES-1:0]      pixel_out,
   output logic [7:0]                  write_data_r,
   output logic                        write_pulse,
   output logic [7:0]                  read_data,
   output logic [7:0]                  dac_data
);
   // async pins pass three stages; a change counts when stages 2 and 3 agree
   logic [PFD_SYNC_STAGES-1:0] flag_s_r, flag_s_nxt;
   logic [PFD_SYNC_STAGES-1:0] wr_s_r, wr_s_nxt;
   logic [PFD_SYNC_STAGES-1:0] blk_s_r, blk_s_nxt;
   logic                       flag_q_r, flag_q_nxt;
   logic                       wr_q_r, wr_q_nxt;
   logic                       blk_q_r, blk_q_nxt;
   logic [7:0]                 sdiv_r, sdiv_nxt;
   logic [7:0]                 vdiv_r, vdiv_nxt;
   logic                       sclk_r, sclk_nxt;
   logic                       video_clock_out_r, video_clock_out_nxt;
   logic                       extra_r, extra_nxt;
   logic                       nib_latch_r, nib_latch_nxt;
   logic [8*PIX_BYTES-1:0]     pix_r, pix_nxt;
   logic [7:0]                 wdat_r, wdat_nxt;
   logic                       wpul_r, wpul_nxt;
   logic [7:0]                 rdat_r, rdat_nxt;
   logic [7:0]                 dac_r, dac_nxt;
   logic [8*PIX_BYTES-1:0]     nib_data;
   pfd_mode_t                  mode;

   assign mode = pfd_mode_t'({ctrl_reg[PFD_MODE_NIBBLE_BIT], ctrl_reg[PFD_MODE_SPLIT_BIT]});

   // nibble select per pixel byte: each byte repeats the chosen nibble in both halves
   genvar g;
   generate
      for (g = 0; g < PIX_BYTES; g++) begin : g_nib
         assign nib_data[8*g +: 8] = nib_latch_r ?
            {pixel_bus[8*g+4 +: 4], pixel_bus[8*g+4 +: 4]} :
            {pixel_bus[8*g +: 4], pixel_bus[8*g +: 4]};
      end
   endgenerate

   always_comb begin
      logic flag_rise;
      logic wr_rise;
      logic sclk_tick;
      logic video_clock_out_tick;
      flag_rise   = 1'b0;
      wr_rise     = 1'b0;
      sclk_tick   = 1'b0;
      video_clock_out_tick   = 1'b0;
      flag_s_nxt  = {flag_s_r[PFD_SYNC_STAGES-2:0], transfer_or_nibble_flag};
      wr_s_nxt    = {wr_s_r[PFD_SYNC_STAGES-2:0], wr_strobe_n};
      blk_s_nxt   = {blk_s_r[PFD_SYNC_STAGES-2:0], blank_in};
      flag_q_nxt  = flag_q_r;
      wr_q_nxt    = wr_q_r;
      blk_q_nxt   = blk_q_r;
      if (flag_s_r[1] == flag_s_r[2]) begin
         flag_q_nxt = flag_s_r[2];
      end
      if (wr_s_r[1] == wr_s_r[2]) begin
         wr_q_nxt = wr_s_r[2];
      end
      if (blk_s_r[1] == blk_s_r[2]) begin
         blk_q_nxt = blk_s_r[2];
      end
      flag_rise = flag_q_nxt & ~flag_q_r;
      wr_rise   = wr_q_nxt & ~wr_q_r;

      // video clock: free-running divider of the dot clock
      vdiv_nxt = vdiv_r + 8'h01;
      video_clock_out_nxt = video_clock_out_r;
      if (vdiv_r == 8'(VIDEO_DIV/2 - 1)) begin
         vdiv_nxt  = 8'h00;
         video_clock_out_nxt  = ~video_clock_out_r;
         video_clock_out_tick = 1'b1;
      end

      // shift clock: submultiple of dot clock, parked low in blanking
      sdiv_nxt  = sdiv_r;
      sclk_nxt  = sclk_r;
      extra_nxt = extra_r;
      // the extra cycle is one full period, after which the clock parks low again
      if (mode == PFD_SPLIT && blk_q_r && flag_rise) begin
         extra_nxt = 1'b1;
      end
      if (!blk_q_r || extra_r || sclk_r) begin
         sdiv_nxt = sdiv_r + 8'h01;
         if (sdiv_r == 8'(SHIFT_DIV/2 - 1)) begin
            sdiv_nxt  = 8'h00;
            sclk_nxt  = ~sclk_r;
            sclk_tick = ~sclk_r;
            if (sclk_r && blk_q_r) begin
               extra_nxt = 1'b0;
            end
         end
      end else begin
         sdiv_nxt = 8'h00;
      end

      // nibble flag sampled on falling video clock
      // the sample steers the very next shift clock rise; a fall and a rise
      // in one cycle still use the older sample
      nib_latch_nxt = nib_latch_r;
      if (mode == PFD_NIBBLE && video_clock_out_tick && video_clock_out_r) begin
         nib_latch_nxt = flag_q_r;
      end

      // pass-through bypasses the nibble and shift clock paths entirely
      pix_nxt = pix_r;
      if (pass_through_en) begin
         pix_nxt = {{(8*PIX_BYTES-8){1'b0}}, pass_bus};
      end else if (sclk_tick) begin
         unique case (mode)
            PFD_NIBBLE: pix_nxt = nib_data;
            PFD_OFF,
            PFD_SPLIT:  pix_nxt = pixel_bus;
            default:    pix_nxt = pixel_bus;
         endcase
      end

      // host write captured on strobe rising edge
      wdat_nxt = wdat_r;
      wpul_nxt = wr_rise;
      if (wr_rise) begin
         wdat_nxt = data_in;
      end

      // converter and readback widths follow the pin level on every edge
      if (width_sel) begin
         rdat_nxt = hold_entry;
         dac_nxt  = hold_entry;
      end else begin
         rdat_nxt = {2'b00, hold_entry[5:0]};
         dac_nxt  = {hold_entry[5:0], 2'b00};
      end
   end

   // synchronisers and filtered pin levels
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         // strobe stages reset to the idle high level, so leaving reset is no write
         flag_s_r    <= '0;
         wr_s_r      <= '1;
         blk_s_r     <= '0;
         flag_q_r    <= 1'b0;
         wr_q_r      <= 1'b1;
         blk_q_r     <= 1'b0;
      end else begin
         flag_s_r    <= flag_s_nxt;
         wr_s_r      <= wr_s_nxt;
         blk_s_r     <= blk_s_nxt;
         flag_q_r    <= flag_q_nxt;
         wr_q_r      <= wr_q_nxt;
         blk_q_r     <= blk_q_nxt;
      end
   end

   // shift and video clock generation, nibble sample
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sdiv_r      <= 8'h00;
         vdiv_r      <= 8'h00;
         sclk_r      <= 1'b0;
         video_clock_out_r      <= 1'b0;
         extra_r     <= 1'b0;
         nib_latch_r <= 1'b0;
      end else begin
         sdiv_r      <= sdiv_nxt;
         vdiv_r      <= vdiv_nxt;
         sclk_r      <= sclk_nxt;
         video_clock_out_r      <= video_clock_out_nxt;
         extra_r     <= extra_nxt;
         nib_latch_r <= nib_latch_nxt;
      end
   end

   // pixel, host write and converter data registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pix_r       <= '0;
         wdat_r      <= PFD_BYTE_ZERO;
         wpul_r      <= 1'b0;
         rdat_r      <= PFD_BYTE_ZERO;
         dac_r       <= PFD_BYTE_ZERO;
      end else begin
         pix_r       <= pix_nxt;
         wdat_r      <= wdat_nxt;
         wpul_r      <= wpul_nxt;
         rdat_r      <= rdat_nxt;
         dac_r       <= dac_nxt;
      end
   end

   assign shift_clk_out   = sclk_r;
   assign video_clock_out = video_clock_out_r;
   assign pixel_out       = pix_r;
   assign write_data_r    = wdat_r;
   assign write_pulse     = wpul_r;
   assign read_data       = rdat_r;
   assign dac_data        = dac_r;
endmodule // pfd_core

// file: dv/pfd_core_sva.sv
// assertion checker for the pixel flag and width block
`timescale 1ns/10ps
module pfd_core_sva #(parameter int PIX_BYTES = 4) (
   input wire logic                   core_clk,
   input wire logic                   nrst,
   input wire logic [7:0]             ctrl_reg,
   input wire logic                   blank_in,
   input wire logic                   pass_through_en,
   input wire logic [7:0]             pass_bus,
   input wire logic                   wr_strobe_n,
   input wire logic [7:0]             data_in,
   input wire logic                   width_sel,
   input wire logic [7:0]             hold_entry,
   input wire logic                   shift_clk_out,
   input wire logic                   video_clock_out,
   input wire logic [8*PIX_BYTES-1:0] pixel_out,
   input wire logic [7:0]             write_data_r,
   input wire logic                   write_pulse,
   input wire logic [7:0]             read_data,
   input wire logic [7:0]             dac_data
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [5:0] lo;
   assign lo = hold_entry[5:0];
   a_width_eight: assert property (
      width_sel |=> dac_data == $past(hold_entry)) else $error("eight bit dac wrong");
   a_width_six: assert property (
      !width_sel |=> dac_data == {$past(lo), 2'b00}) else $error("six bit dac wrong");
   a_read_six: assert property (
      !width_sel |=> read_data == {2'b00, $past(lo)}) else $error("six bit read wrong");
   a_pass_out: assert property (
      pass_through_en |=> pixel_out == 32'($past(pass_bus))) else $error("pass bus wrong");
   // blank needs four cycles to filter, then a high clock may run two more
   a_blank_gate: assert property (
      (ctrl_reg[3:2] == 2'b00 && blank_in) [*7] |-> !shift_clk_out) else $error("sclk in blank");
   a_video_clock_out_shape: assert property (
      $rose(video_clock_out) |=> video_clock_out [*3] ##1 !video_clock_out [*4])
      else $error("video clock shape wrong");
   a_write_lat: assert property (
      $rose(wr_strobe_n) |-> ##[2:6] write_pulse) else $error("write pulse missing");
   a_write_data: assert property (
      write_pulse |-> write_data_r == data_in) else $error("write data wrong");
   a_pulse_one: assert property (
      write_pulse |=> !write_pulse) else $error("write pulse too long");
   c_write: cover property (write_pulse);
   c_split: cover property (ctrl_reg[3:2] == 2'b01 && blank_in && $rose(shift_clk_out));
   c_nibble: cover property (ctrl_reg[3:2] == 2'b10 && $fell(video_clock_out));
endmodule // pfd_core_sva

// file: dv/pfd_host_model.sv
// host processor model driving write strobes
`timescale 1ns/10ps
module pfd_host_model (
   input  wire logic       core_clk,
   input  wire logic       req,
   input  wire logic [7:0] wdata,
   output logic            wr_strobe_n,
   output logic [7:0]      data_in
);
   int cnt = 0;
   initial wr_strobe_n = 1'b1;
   initial data_in = 8'h00;
   // strobe low four cycles, data held six past the rise, then the data bus inverts
   always @(posedge core_clk) begin
      if (cnt == 0 && req) begin
         data_in <= wdata;
         wr_strobe_n <= 1'b0;
         cnt <= 1;
      end else if (cnt > 0) begin
         cnt <= (cnt == 10) ? 0 : cnt + 1;
         if (cnt == 4) wr_strobe_n <= 1'b1;
         if (cnt == 10) data_in <= ~data_in;
      end
   end
endmodule // pfd_host_model

// file: dv/pfd_core_tb.sv
// self-checking bench for the pixel flag and width block
`timescale 1ns/10ps
module pfd_core_tb;
   import pfd_pkg::*;
   logic        core_clk = 0, nrst = 0, blank_in = 0, transfer_or_nibble_flag = 0;
   logic        pass_through_en = 1, width_sel = 1, req = 0, wr_strobe_n, write_pulse;
   logic        shift_clk_out, video_clock_out, sclk_d = 0;
   logic [7:0]  ctrl_reg = 8'h00, pass_bus = 8'h00, hold_entry = 8'h00, wdata = 8'h00;
   logic [7:0]  data_in, write_data_r, read_data, dac_data, s = 8'h14;
   logic [31:0] pixel_bus = 32'h0, pixel_out;
   int          fails = 0, tests_run = 0, rises = 0, n, i;
   logic [7:0]  q[$];
   always #50 core_clk = ~core_clk;
   pfd_core u_dut (.*);
   pfd_host_model u_host (.*);
   always @(posedge core_clk) begin
      sclk_d <= shift_clk_out;
      if (shift_clk_out && !sclk_d) rises++;
   end
   function automatic logic [7:0] lfsr(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [31:0] nib(logic [31:0] p, logic hi);
      for (int b = 0; b < 32; b += 8) nib[b +: 8] = hi ? {2{p[b+4 +: 4]}} : {2{p[b +: 4]}};
   endfunction
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
   endtask
   initial begin
      tick(16);
      nrst <= 1'b1;
      for (i = 0; i < 40; i++) begin
         s = lfsr(s);
         tick(1);
         hold_entry <= s;
         width_sel <= s[0];
         pass_bus <= ~s;
         tick(1);
         #1;
         chk(read_data, s[0] ? s : {2'b00, s[5:0]});
         chk(dac_data, s[0] ? s : {s[5:0], 2'b00});
         chk(pixel_out, {24'h000000, ~s});
      end
      for (i = 0; i < 4; i++) begin
         s = lfsr(s);
         q.push_back(s);
         tick(1);
         wdata <= s;
         req <= 1'b1;
         tick(1);
         req <= 1'b0;
         #1;
         for (n = 0; n < 30 && write_pulse !== 1'b1; n++) begin
            tick(1);
            #1;
         end
         if (n == 30) fails++;
         if (n == 30) end_sim();
         chk(write_data_r, q.pop_front());
         tick(12);
      end
      pass_through_en <= 1'b0;
      ctrl_reg <= 8'h04; // bits 3 and 2 are never set together
      blank_in <= 1'b1;
      tick(10);
      #1 rises = 0;
      tick(10);
      #1 chk(rises, 0);
      tick(1);
      transfer_or_nibble_flag <= 1'b1;
      tick(15);
      #1 chk(rises, 1);
      tick(1);
      ctrl_reg <= 8'h00;
      transfer_or_nibble_flag <= 1'b0;
      tick(5);
      #1 rises = 0;
      tick(1);
      transfer_or_nibble_flag <= 1'b1;
      tick(15);
      #1 chk(rises, 0);
      tick(1);
      ctrl_reg <= 8'h08;
      blank_in <= 1'b0;
      pixel_bus <= {s, ~s, lfsr(s), 8'h5a};
      tick(40);
      #1 chk(pixel_out, nib(pixel_bus, 1'b1));
      tick(1);
      transfer_or_nibble_flag <= 1'b0;
      tick(40);
      #1 chk(pixel_out, nib(pixel_bus, 1'b0));
      tick(1);
      ctrl_reg <= 8'h00;
      transfer_or_nibble_flag <= 1'b1;
      tick(20);
      #1 chk(pixel_out, pixel_bus);
      end_sim();
   end
endmodule // pfd_core_tb
bind pfd_core pfd_core_sva #(.PIX_BYTES(PIX_BYTES)) u_sva (.*);
